// ---- cbt_top.sv ----
/*
  Bit timing registers, bit timing engine and interrupt identifier of a
  stand-alone CAN controller, behind a byte-wide parallel host port.
  Assumes all inputs synchronous to REF_CLK_I; message objects and the
  status register live outside and report through plain ports.
*/
//Behaviour
//RULE1 - Jump width 0 to 3; one more quantum is the real resync limit.
//RULE2 - Prescaler 0 to 63; one quantum lasts prescaler plus one clocks.
//RULE3 - Sampling bit one takes three samples and a majority, zero one sample.
//RULE4 - Segment after sample point programmed 0 to 7, lasts value plus one quanta.
//RULE5 - Segment before sample point programmed 1 to 15, lasts value plus one quanta.
//RULE6 - Both timing registers and the identifier read zero after reset.
//RULE7 - Identifier is read-only and reads zero when nothing is pending.
//RULE8 - Enabled status update makes the identifier read one.
//RULE9 - Objects 1 to 14 report number plus two; object 15 reports two.
//RULE10 - Status change outranks every message object.
//RULE11 - Without status change, identifier follows lowest pending object code.
//RULE12 - Status read at code one releases the pin within four clocks plus 145 ns.
//RULE13 - Object flag clear updates pin and identifier after 3 to 14 clocks.
//RULE14 - Status changes before acknowledge merge into one interrupt.
//RULE15 - Host checks all status bits on each status interrupt.
//RULE16 - Enabled reception pulls the pin low and loads the object code.
//RULE17 - All-ones writes to the resync address are answered with AAH.
//RULE18 - Sync segment is one quantum; bit is three plus both segment fields.
//RULE19 - Bus level is read at the end of the segment before the sample point.
//RULE20 - Field layout: jump 7:6, prescaler 5:0; sampling 7, seg2 6:4, seg1 3:0.
//RULE21 - Extra samples come from the two quanta before the sample point.
`timescale 1ns/1ps
`include "cbt_regs.svh"

module cbt_top
  import cbt_pkg::*;
#(
  parameter int OBJ_COUNT   = 15,
  parameter int CLEAR_DELAY = `CBT_CLR_MIN_CYC
) (
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic [7:0]           ADDR_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  input  wire logic [7:0]           WDATA_I,
  output cbt_byte_t                 RDATA_O,
  output logic                      INT_N_O,
  input  wire logic [7:0]           STATUS_I,
  input  wire logic                 STATUS_UPDATE_I,
  input  wire logic                 STATUS_CHANGE_IRQ_ENABLE_I,
  input  wire logic                 GLOBAL_IRQ_ENABLE_I,
  input  wire logic [OBJ_COUNT-1:0] OBJ_RX_DONE_I,
  input  wire logic [OBJ_COUNT-1:0] OBJ_TX_DONE_I,
  input  wire logic [OBJ_COUNT-1:0] OBJECT_RECEIVE_IRQ_ENABLE_I,
  input  wire logic [OBJ_COUNT-1:0] OBJECT_TRANSMIT_IRQ_ENABLE_I,
  output logic [OBJ_COUNT-1:0]      OBJECT_IRQ_PENDING_O,
  input  wire logic                 RX_I,
  output logic                      QUANTUM_TICK_O,
  output logic                      BIT_START_O,
  output logic                      SAMPLE_POINT_O,
  output logic                      BIT_VALUE_O
);

  generate
    if (OBJ_COUNT != 15) begin : g_bad_count
      $error("cbt_top serves exactly fifteen objects");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic majority(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic is_object_ctrl(input logic [7:0] a);
    return (a[3:0] == 4'h0) && (a[7:4] != 4'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  cbt_prescale_jump_s        prescale_jump;
  cbt_segments_s             segments;
  cbt_byte_t                 code;
  logic                      status_ack;
  logic                      status_set;
  logic [OBJ_COUNT-1:0]      obj_set;
  logic [OBJ_COUNT-1:0]      obj_clr;
  logic [OBJ_COUNT-1:0]      host_obj_set;
  logic [OBJ_COUNT-1:0]      host_obj_clr;
  logic [OBJ_COUNT-1:0]      pending;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prescale_jump <= `CBT_RST_BT_PRESCALE; // RULE6
      segments      <= `CBT_RST_BT_SEGMENTS; // RULE6
    end else if (WR_I) begin
      if (ADDR_I == `CBT_OFS_BT_PRESCALE) begin
        prescale_jump <= WDATA_I; // RULE20
      end
      if (ADDR_I == `CBT_OFS_BT_SEGMENTS) begin
        segments <= WDATA_I; // RULE20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host writes to object control bytes: low pair 01 clears, 10 sets

  always_comb begin
    host_obj_set = '0;
    host_obj_clr = '0;
    if (WR_I && is_object_ctrl(ADDR_I)) begin
      if (WDATA_I[1:0] == 2'b01) begin
        host_obj_clr[ADDR_I[7:4] - 4'h1] = 1'b1; // RULE13
      end
      if (WDATA_I[1:0] == 2'b10) begin
        host_obj_set[ADDR_I[7:4] - 4'h1] = 1'b1;
      end
    end
  end

  always_comb begin
    obj_set = host_obj_set
            | ({OBJ_COUNT{GLOBAL_IRQ_ENABLE_I}} & OBJ_RX_DONE_I
               & OBJECT_RECEIVE_IRQ_ENABLE_I) // RULE16
            | ({OBJ_COUNT{GLOBAL_IRQ_ENABLE_I}} & OBJ_TX_DONE_I
               & OBJECT_TRANSMIT_IRQ_ENABLE_I);
    obj_clr    = host_obj_clr;
    status_set = STATUS_UPDATE_I & STATUS_CHANGE_IRQ_ENABLE_I; // RULE8
    status_ack = RD_I && (ADDR_I == `CBT_OFS_STATUS) && (code == `CBT_CODE_STATUS); // RULE12
  end

  cbt_int_ident #(
    .OBJ_COUNT   (OBJ_COUNT),
    .CLEAR_DELAY (CLEAR_DELAY)
  ) u_ident (
    .clk_i                (REF_CLK_I),
    .rst_n_i              (RST_N_I),
    .status_set_i         (status_set),
    .status_ack_i         (status_ack),
    .obj_set_i            (obj_set),
    .obj_clr_i            (obj_clr),
    .code_o               (code),
    .int_n_o              (INT_N_O),
    .object_irq_pending_o (pending)
  );

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OBJECT_IRQ_PENDING_O <= '0;
    end else begin
      OBJECT_IRQ_PENDING_O <= pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; an all-ones write to the resync address primes the AAH answer

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
    end else if (WR_I && ADDR_I == `CBT_OFS_RESYNC) begin
      RDATA_O <= (WDATA_I == `CBT_RESYNC_FILL) ? `CBT_RESYNC_REPLY : 8'h00; // RULE17
    end else if (RD_I) begin
      if (ADDR_I == `CBT_OFS_BT_PRESCALE) begin
        RDATA_O <= prescale_jump;
      end else if (ADDR_I == `CBT_OFS_BT_SEGMENTS) begin
        RDATA_O <= segments;
      end else if (ADDR_I == `CBT_OFS_IRQ_CODE) begin
        RDATA_O <= code; // RULE7
      end else if (ADDR_I == `CBT_OFS_STATUS) begin
        RDATA_O <= STATUS_I;
      end else if (is_object_ctrl(ADDR_I)) begin
        RDATA_O <= {6'h3F, pending[ADDR_I[7:4] - 4'h1], ~pending[ADDR_I[7:4] - 4'h1]};
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time quantum divider

  logic [5:0] presc_cnt;
  logic       tq_tick;

  always_comb begin
    tq_tick = (presc_cnt == prescale_jump.quantum_prescaler); // RULE2
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      presc_cnt <= 6'h00;
    end else if (tq_tick) begin
      presc_cnt <= 6'h00;
    end else begin
      presc_cnt <= presc_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling edge of the bus, held until the next quantum

  logic rx_prev;
  logic edge_seen;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= RX_I;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      edge_seen <= 1'b0;
    end else if (rx_prev && !RX_I) begin
      edge_seen <= 1'b1;
    end else if (tq_tick) begin
      edge_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit segment sequencer

  cbt_seg_e   seg;
  logic [4:0] q_cnt;
  logic [4:0] seg_len;
  logic [4:0] jump_len;
  logic [4:0] pre_len;
  logic [4:0] post_len;
  logic [4:0] late_err;
  logic [4:0] early_err;
  logic       sample_now;

  always_comb begin
    jump_len   = {3'h0, prescale_jump.resync_jump_width} + 5'h01; // RULE1
    pre_len    = {1'b0, segments.pre_sample_segment} + 5'h01; // RULE5
    post_len   = {2'h0, segments.post_sample_segment} + 5'h01; // RULE4
    late_err   = q_cnt + 5'h01;
    early_err  = seg_len - q_cnt;
    sample_now = tq_tick && seg == CBT_PRE && q_cnt == seg_len - 5'h01 && !edge_seen; // RULE19
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seg     <= CBT_SYNC;
      q_cnt   <= 5'h00;
      seg_len <= 5'h01;
    end else if (tq_tick) begin
      unique case (seg)
        CBT_SYNC: begin
          seg     <= CBT_PRE; // RULE18
          q_cnt   <= 5'h00;
          seg_len <= pre_len;
        end
        CBT_PRE: begin
          if (q_cnt == seg_len - 5'h01 && !edge_seen) begin
            seg     <= CBT_POST;
            q_cnt   <= 5'h00;
            seg_len <= post_len;
          end else begin
            q_cnt <= q_cnt + 5'h01;
            if (edge_seen) begin
              seg_len <= seg_len + min5(late_err, jump_len); // RULE1
            end
          end
        end
        CBT_POST: begin
          if (edge_seen && early_err <= jump_len) begin
            seg     <= CBT_PRE; // RULE1
            q_cnt   <= 5'h00;
            seg_len <= pre_len;
          end else if (edge_seen) begin
            seg_len <= seg_len - jump_len; // RULE1
            q_cnt   <= q_cnt + 5'h01;
          end else if (q_cnt == seg_len - 5'h01) begin
            seg     <= CBT_SYNC;
            q_cnt   <= 5'h00;
            seg_len <= 5'h01; // RULE18
          end else begin
            q_cnt <= q_cnt + 5'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling: history of the two previous quanta feeds the vote

  logic [1:0] rx_hist;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_hist <= 2'b11;
    end else if (tq_tick) begin
      rx_hist <= {rx_hist[0], RX_I}; // RULE21
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BIT_VALUE_O <= 1'b1;
    end else if (sample_now) begin
      if (segments.triple_sample) begin
        BIT_VALUE_O <= majority(rx_hist[1], rx_hist[0], RX_I); // RULE3
      end else begin
        BIT_VALUE_O <= RX_I; // RULE3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing strobes

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      QUANTUM_TICK_O <= 1'b0;
      SAMPLE_POINT_O <= 1'b0;
      BIT_START_O    <= 1'b0;
    end else begin
      QUANTUM_TICK_O <= tq_tick;
      SAMPLE_POINT_O <= sample_now; // RULE19
      BIT_START_O    <= tq_tick && (seg == CBT_SYNC);
    end
  end

endmodule

// ---- cbt_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  bit timing and interrupt identifier block.
  Assumes a byte-wide host port with 8-bit addresses and a 25 ns clock.
*/
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// Offsets
`define CBT_OFS_STATUS      8'h01
`define CBT_OFS_BT_PRESCALE 8'h3F
`define CBT_OFS_BT_SEGMENTS 8'h4F
`define CBT_OFS_IRQ_CODE    8'h5F
`define CBT_OFS_RESYNC      8'hFF

// Field positions
`define CBT_JUMP_MSB        7
`define CBT_JUMP_LSB        6
`define CBT_PRESC_MSB       5
`define CBT_PRESC_LSB       0
`define CBT_TRIPLE_BIT      7
`define CBT_SEG2_MSB        6
`define CBT_SEG2_LSB        4
`define CBT_SEG1_MSB        3
`define CBT_SEG1_LSB        0

// Reset values and fixed answers
`define CBT_RST_BT_PRESCALE 8'h00
`define CBT_RST_BT_SEGMENTS 8'h00
`define CBT_RST_IRQ_CODE    8'h00
`define CBT_RESYNC_REPLY    8'hAA
`define CBT_RESYNC_FILL     8'hFF

// Interrupt codes
`define CBT_CODE_NONE       8'h00
`define CBT_CODE_STATUS     8'h01
`define CBT_CODE_OBJ15      8'h02
`define CBT_CODE_OBJ_BASE   8'h02

// Timing
`define CBT_CLK_NS          25
`define CBT_STAT_EXTRA_NS   145
`define CBT_STAT_BASE_CYC   4
`define CBT_STAT_MAX_CYC    (`CBT_STAT_BASE_CYC + (`CBT_STAT_EXTRA_NS / `CBT_CLK_NS))
`define CBT_CLR_MIN_CYC     3
`define CBT_CLR_MAX_CYC     14

`endif

// ---- cbt_pkg.sv ----
/*
  Types of the bit timing and interrupt identifier block.
  Assumes cbt_regs.svh for all numeric constants.
*/
package cbt_pkg;

  typedef logic [7:0] cbt_byte_t;

  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
  } cbt_prescale_jump_s;

  typedef struct packed {
    logic       triple_sample;
    logic [2:0] post_sample_segment;
    logic [3:0] pre_sample_segment;
  } cbt_segments_s;

  typedef enum logic [1:0] {
    CBT_SYNC,
    CBT_PRE,
    CBT_POST
  } cbt_seg_e;

endpackage

// ---- cbt_int_ident.sv ----
/*
  Interrupt pending flags and the interrupt identifier code with its pin.
  Assumes one-cycle set and clear strobes from the host port logic.
*/
`timescale 1ns/1ps
`include "cbt_regs.svh"

module cbt_int_ident
  import cbt_pkg::*;
#(
  parameter int OBJ_COUNT   = 15,
  parameter int CLEAR_DELAY = `CBT_CLR_MIN_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 status_set_i,
  input  wire logic                 status_ack_i,
  input  wire logic [OBJ_COUNT-1:0] obj_set_i,
  input  wire logic [OBJ_COUNT-1:0] obj_clr_i,
  output cbt_byte_t                 code_o,
  output logic                      int_n_o,
  output logic [OBJ_COUNT-1:0]      object_irq_pending_o
);

  generate
    if (OBJ_COUNT != 15) begin : g_bad_count
      $error("cbt_int_ident serves exactly fifteen objects");
    end
    if (CLEAR_DELAY < `CBT_CLR_MIN_CYC || CLEAR_DELAY > `CBT_CLR_MAX_CYC - 1) begin : g_bad_dly
      $error("cbt_int_ident clear delay out of range");
    end
  endgenerate

  logic       status_pend;
  logic [3:0] hold_cnt;
  cbt_byte_t  next_code;

  // Lowest code wins; status first, then object 15, then objects 1 to 14
  function automatic cbt_byte_t encode(input logic st, input logic [OBJ_COUNT-1:0] p);
    cbt_byte_t c;
    c = `CBT_CODE_NONE;
    for (int i = OBJ_COUNT - 2; i >= 0; i--) begin
      if (p[i]) begin
        c = `CBT_CODE_OBJ_BASE + cbt_byte_t'(i + 1); // RULE9
      end
    end
    if (p[OBJ_COUNT-1]) begin
      c = `CBT_CODE_OBJ15; // RULE9
    end
    if (st) begin
      c = `CBT_CODE_STATUS; // RULE10
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status change flag: later events merge into the pending one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_pend <= 1'b0;
    end else if (status_set_i) begin
      status_pend <= 1'b1; // RULE14
    end else if (status_ack_i) begin
      status_pend <= 1'b0; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object pending flags: a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      object_irq_pending_o <= '0;
    end else begin
      object_irq_pending_o <= (object_irq_pending_o & ~obj_clr_i) | obj_set_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold code and pin after an object clear so both update after the delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt <= 4'h0;
    end else if (|obj_clr_i) begin
      hold_cnt <= 4'(CLEAR_DELAY - 1); // RULE13
    end else if (hold_cnt != 4'h0) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
  end

  always_comb begin
    next_code = encode(status_pend, object_irq_pending_o); // RULE11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identifier and pin update together
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o  <= `CBT_RST_IRQ_CODE; // RULE6
      int_n_o <= 1'b1;
    end else if (hold_cnt == 4'h0 && !(|obj_clr_i)) begin
      code_o  <= next_code; // RULE7
      int_n_o <= (next_code == `CBT_CODE_NONE); // RULE16
    end
  end

endmodule

// ---- cbt_monitor.sv ----
/*
  Port checker of cbt_top: register reads, interrupt pin timing, bit timing.
  Assumes bind into cbt_top and host strobes one cycle long.
*/
`timescale 1ns/1ps
module cbt_monitor
  import cbt_pkg::*;
#(
  parameter int OBJ_COUNT   = 15,
  parameter int CLEAR_DELAY = 3
) (
  input wire logic                 REF_CLK_I,
  input wire logic                 RST_N_I,
  input wire logic [7:0]           ADDR_I,
  input wire logic                 WR_I,
  input wire logic                 RD_I,
  input wire logic [7:0]           WDATA_I,
  input wire cbt_byte_t            RDATA_O,
  input wire logic                 INT_N_O,
  input wire logic                 STATUS_UPDATE_I,
  input wire logic                 STATUS_CHANGE_IRQ_ENABLE_I,
  input wire logic                 GLOBAL_IRQ_ENABLE_I,
  input wire logic [OBJ_COUNT-1:0] OBJ_RX_DONE_I,
  input wire logic [OBJ_COUNT-1:0] OBJECT_RECEIVE_IRQ_ENABLE_I,
  input wire logic [OBJ_COUNT-1:0] OBJECT_IRQ_PENDING_O,
  input wire logic                 RX_I,
  input wire logic                 BIT_START_O,
  input wire logic                 QUANTUM_TICK_O,
  input wire logic                 SAMPLE_POINT_O
);
  cbt_prescale_jump_s bt0;
  cbt_segments_s      bt1;
  logic [5:0]         cq;
  logic [4:0]         cs;
  logic [1:0]         ok;
  logic               rx_q;
  logic               clr_one;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Clear write on the only pending object while the pin is low
  assign clr_one = WR_I && ADDR_I[3:0] == 4'h0 && ADDR_I[7:4] != 4'h0 && WDATA_I[1:0] == 2'b01
                   && $onehot(OBJECT_IRQ_PENDING_O) && !INT_N_O
                   && OBJECT_IRQ_PENDING_O[ADDR_I[7:4] - 4'h1];
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bt0 <= '0;
      bt1 <= '0;
    end else if (WR_I && ADDR_I == 8'h3F) begin
      bt0 <= cbt_prescale_jump_s'(WDATA_I);
    end else if (WR_I && ADDR_I == 8'h4F) begin
      bt1 <= cbt_segments_s'(WDATA_I);
    end
  end
  // Timing checks wait three sample points after a change
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ok <= 2'h0;
    end else if ((WR_I && (ADDR_I == 8'h3F || ADDR_I == 8'h4F)) || RX_I != rx_q) begin
      ok <= 2'h0;
    end else if (SAMPLE_POINT_O && ok != 2'h3) begin
      ok <= ok + 2'h1;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cq <= 6'h0;
      cs <= 5'h0;
      rx_q <= 1'b1;
    end else begin
      cq <= QUANTUM_TICK_O ? 6'h0 : cq + 6'h1;
      cs <= SAMPLE_POINT_O ? 5'h0 : cs + 5'(QUANTUM_TICK_O);
      rx_q <= RX_I;
    end
  end
  AST_RD_PRESCALE: assert property (
    RD_I && ADDR_I == 8'h3F |=> RDATA_O == cbt_byte_t'(bt0)) else $error("prescale readback");
  AST_RD_SEGMENTS: assert property (
    RD_I && ADDR_I == 8'h4F |=> RDATA_O == cbt_byte_t'(bt1)) else $error("segments readback");
  AST_RESYNC: assert property (
    WR_I && ADDR_I == 8'hFF && WDATA_I == 8'hFF |=> RDATA_O == 8'hAA) else $error("resync reply");
  AST_STAT_SET: assert property (
    STATUS_UPDATE_I && STATUS_CHANGE_IRQ_ENABLE_I |-> ##2 !INT_N_O) else $error("status irq");
  AST_RX_SET: assert property (
    GLOBAL_IRQ_ENABLE_I && |(OBJ_RX_DONE_I & OBJECT_RECEIVE_IRQ_ENABLE_I) |-> ##2
    (!INT_N_O && |(OBJECT_IRQ_PENDING_O & $past(OBJ_RX_DONE_I, 2)))) else $error("rx irq");
  AST_STAT_ACK: assert property (
    RD_I && ADDR_I == 8'h01 && !INT_N_O && OBJECT_IRQ_PENDING_O == '0 |-> ##[1:9] INT_N_O)
    else $error("status ack");
  AST_CLR_OBJ: assert property (
    clr_one |=> !INT_N_O [*3] ##[1:12] INT_N_O) else $error("clear delay");
  AST_QUANTUM: assert property (
    QUANTUM_TICK_O && ok == 2'h3 |-> cq == bt0.quantum_prescaler) else $error("quantum len");
  AST_BIT_LEN: assert property (
    SAMPLE_POINT_O && ok == 2'h3 |-> cs + 5'(QUANTUM_TICK_O) == 5'(bt1.pre_sample_segment)
    + 5'(bt1.post_sample_segment) + 5'h3) else $error("bit length");
  AST_SYNC: assert property (
    BIT_START_O && ok == 2'h3 |-> cs == 5'(bt1.post_sample_segment) + 5'h1) else $error("sync");
  CV_BIT: cover property (SAMPLE_POINT_O && ok == 2'h3);
  CV_PIN: cover property (!INT_N_O ##1 INT_N_O);
  CV_RESYNC: cover property (WR_I && ADDR_I == 8'hFF);
endmodule
bind cbt_top cbt_monitor #(.OBJ_COUNT(OBJ_COUNT), .CLEAR_DELAY(CLEAR_DELAY)) u_mon (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .INT_N_O(INT_N_O), .STATUS_UPDATE_I(STATUS_UPDATE_I),
  .STATUS_CHANGE_IRQ_ENABLE_I(STATUS_CHANGE_IRQ_ENABLE_I), .RX_I(RX_I),
  .GLOBAL_IRQ_ENABLE_I(GLOBAL_IRQ_ENABLE_I), .OBJ_RX_DONE_I(OBJ_RX_DONE_I),
  .OBJECT_RECEIVE_IRQ_ENABLE_I(OBJECT_RECEIVE_IRQ_ENABLE_I), .QUANTUM_TICK_O(QUANTUM_TICK_O),
  .BIT_START_O(BIT_START_O),
  .OBJECT_IRQ_PENDING_O(OBJECT_IRQ_PENDING_O), .SAMPLE_POINT_O(SAMPLE_POINT_O));

// ---- cbt_host.sv ----
/*
  Host processor model: byte register cycles, status service, port resync.
  Assumes one-cycle strobes and read data valid the cycle after the strobe.
*/
`timescale 1ns/1ps
module cbt_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      wdata_o
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Released address and data lines show the inverse of the last value
  task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycle(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cycle(a, 8'h00, 1'b0);
    d = rdata_i;
  endtask
  // Status interrupt served by reading the whole status byte
  task automatic svc_status(output logic [7:0] d);
    rd(8'h01, d);
  endtask
  // All-ones bytes until the sync pattern comes back, eight at most
  task automatic resync(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      wr(8'hFF, 8'hFF);
      ok = (rdata_i === 8'hAA);
    end
  endtask
endmodule

// ---- tb.sv ----
/*
  Testbench of cbt_top: registers, interrupt codes, bit timing.
  Assumes cbt_host on the register port and cbt_monitor bound.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("[FAIL] %s exp %h got %h", n, (e), (g)); \
    end \
  end
module tb;
  import cbt_pkg::*;
  localparam int CL[3] = '{14, 2, 4};
  localparam logic [7:0] NX[3] = '{8'h05, 8'h07, 8'h00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  cbt_byte_t   rdata;
  logic        int_n;
  logic [7:0]  status = 8'h00;
  logic        st_upd = 1'b0;
  logic        st_en = 1'b1;
  logic        g_en = 1'b1;
  logic [14:0] rx_done = '0;
  logic [14:0] tx_done = '0;
  logic [14:0] rx_en = '1;
  logic [14:0] tx_en = '1;
  logic [14:0] pend;
  logic        rx = 1'b1;
  logic        spt;
  logic        bval;
  logic [31:0] seed = 32'hAC6BC5FF;
  int          err_count = 0;
  int          checks_done = 0;
  always #12.5 clk = ~clk;
  cbt_top #(.OBJ_COUNT(15), .CLEAR_DELAY(3)) u_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata),
    .RDATA_O(rdata), .INT_N_O(int_n), .STATUS_I(status), .STATUS_UPDATE_I(st_upd),
    .STATUS_CHANGE_IRQ_ENABLE_I(st_en), .GLOBAL_IRQ_ENABLE_I(g_en), .OBJ_RX_DONE_I(rx_done),
    .OBJ_TX_DONE_I(tx_done), .OBJECT_RECEIVE_IRQ_ENABLE_I(rx_en), .RX_I(rx),
    .OBJECT_TRANSMIT_IRQ_ENABLE_I(tx_en), .OBJECT_IRQ_PENDING_O(pend), .QUANTUM_TICK_O(),
    .BIT_START_O(), .SAMPLE_POINT_O(spt), .BIT_VALUE_O(bval));
  cbt_host u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int bit_clocks(int p, int s1, int s2);
    return (p + 1) * (s1 + s2 + 3);
  endfunction
  function automatic logic [7:0] obj_code(int k);
    return (k == 14) ? 8'h02 : 8'(k + 3);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    `CHK("read", e, d)
  endtask
  task automatic wait_sp(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (spt !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic pulse(input int k, input logic tx, input logic st);
    @(negedge clk);
    st_upd = st;
    if (k >= 0 && tx) tx_done[k] = 1'b1;
    if (k >= 0 && !tx) rx_done[k] = 1'b1;
    @(negedge clk);
    st_upd = 1'b0;
    tx_done = '0;
    rx_done = '0;
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] b0;
    logic [7:0] b1;
    logic       ok;
    int         n;
    int         p;
    int         s1;
    int         s2;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h3F, 8'h00);
    rd_chk(8'h4F, 8'h00);
    rd_chk(8'h5F, 8'h00);
    u_host.wr(8'h5F, 8'h3C);
    rd_chk(8'h5F, 8'h00);
    rd_chk(8'h02, 8'h00);
    u_host.resync(ok);
    `CHK("resync", 1'b1, ok)
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 0 : (i == 3) ? 63 : int'(rnd() % 8);
      s1 = (i == 0) ? 1 : (i == 3) ? 15 : int'(1 + rnd() % 15);
      s2 = (i == 0) ? 0 : (i == 3) ? 7 : int'(rnd() % 8);
      d = 8'(rnd());
      rx = d[0];
      b0 = {d[7:6], 6'(p)};
      b1 = {1'(i), 3'(s2), 4'(s1)};
      u_host.wr(8'h3F, b0);
      u_host.wr(8'h4F, b1);
      rd_chk(8'h3F, b0);
      rd_chk(8'h4F, b1);
      repeat (5) wait_sp(n);
      `CHK("bit_clocks", bit_clocks(p, s1, s2), n)
      `CHK("bit_value", rx, bval)
      repeat (n - 1) @(negedge clk);
      rx = !rx;
      @(negedge clk);
      `CHK("vote", i[0] ? !rx : rx, bval)
    end
    for (int k = 0; k < 15; k++) begin
      pulse(k, k[0], 1'b0);
      repeat (2) @(negedge clk);
      rd_chk(8'h5F, obj_code(k));
      `CHK("pend", 15'(1 << k), pend)
      `CHK("int_n", 1'b0, int_n)
      u_host.wr({4'(k + 1), 4'h0}, 8'hFD);
      repeat (16) @(negedge clk);
      rd_chk(8'h5F, 8'h00);
      `CHK("int_n", 1'b1, int_n)
    end
    status = 8'(rnd());
    pulse(-1, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    rd_chk(8'h5F, 8'h01);
    u_host.svc_status(d);
    `CHK("status", status, d)
    repeat (10) @(negedge clk);
    `CHK("int_n", 1'b1, int_n)
    pulse(4, 1'b0, 1'b0);
    pulse(2, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    rd_chk(8'h5F, 8'h05);
    pulse(14, 1'b0, 1'b1);
    pulse(-1, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    rd_chk(8'h5F, 8'h01);
    u_host.svc_status(d);
    repeat (10) @(negedge clk);
    rd_chk(8'h5F, 8'h02);
    for (int m = 0; m < 3; m++) begin
      u_host.wr({4'(CL[m] + 1), 4'h0}, 8'hFD);
      repeat (16) @(negedge clk);
      rd_chk(8'h5F, NX[m]);
    end
    g_en = 1'b0;
    st_en = 1'b0;
    pulse(0, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    `CHK("pend", 15'h0000, pend)
    `CHK("int_n", 1'b1, int_n)
    end_of_test();
  end
endmodule
